// File: design/gpio_cfg_pkg.sv
package gpio_cfg_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  // Printed offsets are not all multiples of four: these are indices
  localparam logic [7:0] idx_pin_six_four   = 8'hd4;
  localparam logic [7:0] idx_pin_six_five   = 8'hd5;
  localparam logic [7:0] idx_pin_six_six    = 8'hd6;
  localparam logic [7:0] idx_pin_six_seven  = 8'hd7;
  localparam logic [7:0] idx_irq_two_map    = 8'hef;
  localparam logic [7:0] idx_irq_one_map    = 8'hf0;
  localparam logic [7:0] idx_ring_filter    = 8'hf5;
  localparam logic [7:0] idx_irq_status     = 8'hf8;
  localparam logic [7:0] idx_irq_enable     = 8'hf9;
  localparam logic [7:0] idx_irq_clear      = 8'hfa;
  localparam logic [7:0] idx_pin_level      = 8'hfb;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         pos_dir        = 0;
  localparam int         pos_pol        = 1;
  localparam int         pos_func_lo    = 3;
  localparam int         pos_grp_en     = 5;
  localparam int         pos_drv        = 7;
  localparam int         pos_filter     = 3;
  localparam int         pos_map_lo     = 4;
  localparam int         pos_kbc_choice = 7;
  localparam logic [7:0] pin_cfg_reset  = 8'h01;
  localparam logic [7:0] irq_map_reset  = 8'h00;
  localparam logic [7:0] ring_reset     = 8'h00;
  localparam logic [7:0] pin_cfg_wmask  = 8'hbb;
  localparam logic [7:0] irq_map_wmask  = 8'hf8;

  // ----------------------------------------------------------------
  // Function codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    func_parallel = 2'h0,
    func_irq      = 2'h1,
    func_gpio     = 2'h2,
    func_kbc      = 2'h3
  } pin_func_e;

  localparam logic [3:0] irq_code_off     = 4'h0;
  localparam logic [3:0] irq_code_invalid = 4'h2;

  // Debounce filter length in cycles at 200 MHz
  localparam int unsigned debounce_cycles = 16;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        open_drain;
    logic        grp_en;
    pin_func_e   func;
    logic        invert;
    logic        input_dir;
  } pin_cfg_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

endpackage

// File: design/event_debounce.sv
`timescale 1ns/1ps
`default_nettype none

// Stable-level filter: output follows input once it held for LEN cycles
module event_debounce #(
  parameter int unsigned LEN = gpio_cfg_pkg::debounce_cycles
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic raw,
  output var  logic clean
);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  localparam int W = $clog2(LEN + 1);
  logic [W-1:0] count;   // Cycles input differs from output

  // Count while input disagrees; a glitch restarts the wait
  always_ff @(posedge clk) begin
    if (reset) begin
      count <= '0;
      clean <= 1'b0;
    end else if (raw == clean) begin
      count <= '0;
    end else if (count == W'(LEN - 1)) begin
      count <= '0;
      clean <= raw;
    end else begin
      count <= count + W'(1);
    end
  end

endmodule

`default_nettype wire

// File: design/irq_line_decode.sv
`timescale 1ns/1ps
`default_nettype none

// Registered one-hot decode of a four-bit interrupt number
module irq_line_decode (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [3:0]  code,
  input  wire logic        active,
  output var  logic [15:0] lines
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Off and invalid codes drive nothing rather than a stray line
  always_ff @(posedge clk) begin
    if (reset) begin
      lines <= 16'h0000;
    end else if (!active || code == gpio_cfg_pkg::irq_code_off ||
                 code == gpio_cfg_pkg::irq_code_invalid) begin
      lines <= 16'h0000;
    end else begin
      lines <= 16'h0001 << code;
    end
  end

endmodule

`default_nettype wire

// File: design/gpio_group6_pin_config.sv
// Behaviour
// - Bit 0 one makes pin input
// - Bit 1 inverts pin both ways
// - Pin 6.4 function: data, IRQ6, GPIO, KBC
// - Ring filter bit 7 picks KBC pin
// - Pin 6.5 function: data, IRQ7, GPIO
// - Pin 6.6 function: data, IRQ8, GPIO
// - Pin 6.7 function: data, IRQ10, GPIO
// - Bit 5 joins combined interrupt two
// - Bit 7 one gives open drain
// - Two combined maps, same layout
// - Map bit 3 enables debounce filter
// - Map bits 7:4 pick IRQ line
// - Map bits 2:0 read zero
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module gpio_group6_pin_config #(
  parameter int unsigned NPIN = 4
) (
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output var  logic [31:0]     prdata,
  output var  logic            pready,
  output var  logic            pslverr,
  input  wire logic [NPIN-1:0] pin_in,
  output var  logic [NPIN-1:0] pin_out,
  output var  logic [NPIN-1:0] pin_oe_n,
  input  wire logic [NPIN-1:0] parallel_data_out,
  output var  logic [NPIN-1:0] parallel_data_in,
  input  wire logic [NPIN-1:0] irq_src,
  output var  logic [NPIN-1:0] irq_pin_in,
  input  wire logic            kbc_port_pin_17,
  input  wire logic            kbc_port_pin_12,
  output var  logic            kbc_port_pin_choice,
  output var  logic [NPIN-1:0] gpio_in_level,
  output var  logic [15:0]     isa_irq_one,
  output var  logic [15:0]     isa_irq_two,
  output var  logic            irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Register index from a byte address; low two bits must be zero
  function automatic logic [7:0] reg_index(input logic [11:0] addr);
    reg_index = addr[9:2];
  endfunction

  // Decoded function code, reserved codes fall back to plain GPIO
  function automatic gpio_cfg_pkg::pin_func_e func_of(input logic [7:0] r, input int p);
    gpio_cfg_pkg::pin_func_e f;
    f = gpio_cfg_pkg::pin_func_e'(r[gpio_cfg_pkg::pos_func_lo +: 2]);
    if (f == gpio_cfg_pkg::func_kbc && p != 0) begin
      f = gpio_cfg_pkg::func_gpio;
    end
    func_of = f;
  endfunction

  // Index of each pin register
  localparam logic [7:0] pin_idx [NPIN] = '{
    gpio_cfg_pkg::idx_pin_six_four, gpio_cfg_pkg::idx_pin_six_five,
    gpio_cfg_pkg::idx_pin_six_six,  gpio_cfg_pkg::idx_pin_six_seven
  };

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]      pin_cfg [NPIN];     // Per-pin configuration
  logic [7:0]      irq_map_one;        // Combined interrupt one map
  logic [7:0]      irq_map_two;        // Combined interrupt two map
  logic [7:0]      ring_filter;        // Only bit 7 is used here
  logic [1:0]      irq_status;         // Sticky combined events
  logic [1:0]      irq_enable;         // Interrupt mask
  logic [NPIN-1:0] pin_level;          // Pin level after polarity
  logic [1:0]      comb_raw;           // Unfiltered combined events
  logic [1:0]      comb_filt;          // Filtered combined events
  logic [1:0]      comb_sel;           // After filter select
  logic [1:0]      comb_sel_d;         // For rising edge detection
  logic            wr_en;              // Write access phase
  logic            rd_en;              // Read access phase
  logic [7:0]      widx;               // Accessed register index
  logic            aligned;            // Word aligned with paddr bits 11:10 zero

  // Writes land only at the edge where the master samples pready high
  assign wr_en   = psel && penable && pwrite && pready;
  assign rd_en   = psel && penable && !pwrite && !pready;
  assign widx    = reg_index(paddr);
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Writable bits only; reserved bits stay zero
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < NPIN; i++) begin
        pin_cfg[i] <= gpio_cfg_pkg::pin_cfg_reset;
      end
    end else if (wr_en && aligned) begin
      for (int i = 0; i < NPIN; i++) begin
        if (widx == pin_idx[i]) begin
          pin_cfg[i] <= pwdata[7:0] & gpio_cfg_pkg::pin_cfg_wmask;
        end
      end
    end
  end

  // Combined maps keep the same layout for both groups
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_map_one <= gpio_cfg_pkg::irq_map_reset;
      irq_map_two <= gpio_cfg_pkg::irq_map_reset;
      ring_filter <= gpio_cfg_pkg::ring_reset;
      irq_enable  <= 2'h0;
    end else if (wr_en && aligned) begin
      if (widx == gpio_cfg_pkg::idx_irq_one_map) begin
        irq_map_one <= pwdata[7:0] & gpio_cfg_pkg::irq_map_wmask;
      end
      if (widx == gpio_cfg_pkg::idx_irq_two_map) begin
        irq_map_two <= pwdata[7:0] & gpio_cfg_pkg::irq_map_wmask;
      end
      if (widx == gpio_cfg_pkg::idx_ring_filter) begin
        ring_filter <= pwdata[7:0] & 8'h80;
      end
      if (widx == gpio_cfg_pkg::idx_irq_enable) begin
        irq_enable <= pwdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // APB read and response
  // ----------------------------------------------------------------
  // One wait state: answer registered in the first access cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (!aligned) begin
        pslverr <= 1'b1;
      end else if (rd_en) begin
        unique case (widx)
          gpio_cfg_pkg::idx_pin_six_four:  prdata[7:0] <= pin_cfg[0];
          gpio_cfg_pkg::idx_pin_six_five:  prdata[7:0] <= pin_cfg[1];
          gpio_cfg_pkg::idx_pin_six_six:   prdata[7:0] <= pin_cfg[2];
          gpio_cfg_pkg::idx_pin_six_seven: prdata[7:0] <= pin_cfg[3];
          gpio_cfg_pkg::idx_irq_one_map:   prdata[7:0] <= irq_map_one;
          gpio_cfg_pkg::idx_irq_two_map:   prdata[7:0] <= irq_map_two;
          gpio_cfg_pkg::idx_ring_filter:   prdata[7:0] <= ring_filter;
          gpio_cfg_pkg::idx_irq_status:    prdata[1:0] <= irq_status;
          gpio_cfg_pkg::idx_irq_enable:    prdata[1:0] <= irq_enable;
          gpio_cfg_pkg::idx_irq_clear:     prdata[7:0] <= 8'h00;
          gpio_cfg_pkg::idx_pin_level:     prdata[NPIN-1:0] <= pin_level;
          // Unmapped index answers with an error
          default:                         pslverr <= 1'b1;
        endcase
      end else if (!(widx inside {pin_idx[0], pin_idx[1], pin_idx[2], pin_idx[3],
                     gpio_cfg_pkg::idx_irq_one_map, gpio_cfg_pkg::idx_irq_two_map,
                     gpio_cfg_pkg::idx_ring_filter, gpio_cfg_pkg::idx_irq_enable,
                     gpio_cfg_pkg::idx_irq_clear})) begin
        pslverr <= 1'b1;
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin datapath
  // ----------------------------------------------------------------
  // Output value per pin before polarity, chosen by function field
  logic [NPIN-1:0] src_val;
  logic            kbc_sel;

  // KBC pin choice, zero picks P17
  assign kbc_sel = ring_filter[gpio_cfg_pkg::pos_kbc_choice] ? kbc_port_pin_12
                                                             : kbc_port_pin_17;

  generate
    for (genvar p = 0; p < NPIN; p++) begin : g_pin
      always_comb begin
        unique case (func_of(pin_cfg[p], p))
          gpio_cfg_pkg::func_parallel: src_val[p] = parallel_data_out[p];
          gpio_cfg_pkg::func_irq:      src_val[p] = irq_src[p];
          gpio_cfg_pkg::func_kbc:      src_val[p] = kbc_sel;
          gpio_cfg_pkg::func_gpio:     src_val[p] = 1'b0;
        endcase
      end
    end
  endgenerate

  // Registered pins; level sampled straight, inputs are synchronous
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_out          <= '0;
      pin_oe_n         <= '1;
      pin_level        <= '0;
      parallel_data_in <= '0;
      irq_pin_in       <= '0;
      gpio_in_level    <= '0;
    end else begin
      for (int p = 0; p < NPIN; p++) begin
        pin_level[p] <= pin_in[p] ^ pin_cfg[p][gpio_cfg_pkg::pos_pol];
        if (pin_cfg[p][gpio_cfg_pkg::pos_dir]) begin
          pin_out[p]  <= 1'b0;
          pin_oe_n[p] <= 1'b1;
        end else if (pin_cfg[p][gpio_cfg_pkg::pos_drv]) begin
          pin_out[p]  <= 1'b0;
          pin_oe_n[p] <= src_val[p] ^ pin_cfg[p][gpio_cfg_pkg::pos_pol];
        end else begin
          pin_out[p]  <= src_val[p] ^ pin_cfg[p][gpio_cfg_pkg::pos_pol];
          pin_oe_n[p] <= 1'b0;
        end
        parallel_data_in[p] <= pin_level[p] &&
                               func_of(pin_cfg[p], p) == gpio_cfg_pkg::func_parallel;
        irq_pin_in[p]       <= pin_level[p] &&
                               func_of(pin_cfg[p], p) == gpio_cfg_pkg::func_irq;
        gpio_in_level[p]    <= pin_level[p];
      end
    end
  end

  // KBC choice shown as a flop
  always_ff @(posedge clk) begin
    if (reset) begin
      kbc_port_pin_choice <= 1'b0;
    end else begin
      kbc_port_pin_choice <= ring_filter[gpio_cfg_pkg::pos_kbc_choice];
    end
  end

  // ----------------------------------------------------------------
  // Combined interrupt events
  // ----------------------------------------------------------------
  logic [NPIN-1:0] grp_mask;

  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      grp_mask[p] = pin_cfg[p][gpio_cfg_pkg::pos_grp_en];
    end
  end

  // Group one holds no pins of this block; kept wired for the map
  assign comb_raw = {|(pin_level & grp_mask), 1'b0};

  generate
    for (genvar g = 0; g < 2; g++) begin : g_filt
      event_debounce #(
        .LEN (gpio_cfg_pkg::debounce_cycles)
      ) u_filt (
        .clk   (clk),
        .reset (reset),
        .raw   (comb_raw[g]),
        .clean (comb_filt[g])
      );
    end
  endgenerate

  assign comb_sel[0] = irq_map_one[gpio_cfg_pkg::pos_filter] ? comb_filt[0] : comb_raw[0];
  assign comb_sel[1] = irq_map_two[gpio_cfg_pkg::pos_filter] ? comb_filt[1] : comb_raw[1];

  irq_line_decode u_dec_one (
    .clk    (clk),
    .reset  (reset),
    .code   (irq_map_one[gpio_cfg_pkg::pos_map_lo +: 4]),
    .active (comb_sel[0]),
    .lines  (isa_irq_one)
  );

  irq_line_decode u_dec_two (
    .clk    (clk),
    .reset  (reset),
    .code   (irq_map_two[gpio_cfg_pkg::pos_map_lo +: 4]),
    .active (comb_sel[1]),
    .lines  (isa_irq_two)
  );

  // ----------------------------------------------------------------
  // Sticky status and interrupt
  // ----------------------------------------------------------------
  // Rising edge sets; a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (reset) begin
      comb_sel_d <= 2'h0;
      irq_status <= 2'h0;
    end else begin
      comb_sel_d <= comb_sel;
      irq_status <= (irq_status &
                     ~((wr_en && aligned && widx == gpio_cfg_pkg::idx_irq_clear)
                       ? pwdata[1:0] : 2'h0)) | (comb_sel & ~comb_sel_d);
    end
  end

  // Level interrupt from enabled sticky bits
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

endmodule

`default_nettype wire

// File: tb/pin_partner.sv
`timescale 1ns/1ps
`default_nettype none

// Board side of the four pins: a pull-up plus an external driver
module pin_partner (
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe_n,
  input  wire logic [3:0] ext_val,
  input  wire logic [3:0] ext_en,
  output wire logic [3:0] pin_in
);
  // ----------------------------------------------------------------
  // Wire level
  // ----------------------------------------------------------------
  // Released pin pulled high
  // The device wins a clash so a bad enable shows as a wrong level
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val) | (pin_oe_n & ~ext_en);
endmodule

`default_nettype wire

// File: tb/gpio_group6_pin_config_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module gpio_cfg_monitor #(
  parameter int unsigned NPIN = 4
) (
  input wire logic            clk,
  input wire logic            reset,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [11:0]     paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic [NPIN-1:0] pin_in,
  input wire logic [NPIN-1:0] pin_out,
  input wire logic [NPIN-1:0] pin_oe_n,
  input wire logic [NPIN-1:0] parallel_data_in,
  input wire logic [NPIN-1:0] irq_pin_in,
  input wire logic            kbc_port_pin_choice,
  input wire logic [NPIN-1:0] gpio_in_level,
  input wire logic [15:0]     isa_irq_two
);
  // ----------------------------------------------------------------
  // Shadow of the configuration, taken at completed writes
  // ----------------------------------------------------------------
  logic [7:0]  cfg [4];   // Pin registers 6.4 to 6.7
  logic        ring;      // Port pin choice bit
  logic [7:0]  map2;      // Combined interrupt two map
  logic [4:0]  settle;    // Cycles since reset or last write
  logic [3:0]  in_dir;    // Per-pin decoded fields
  logic [3:0]  inv;
  logic [3:0]  od;
  logic [3:0]  grp;
  logic [3:0]  fpar;
  logic [3:0]  firq;
  logic [3:0]  act;       // Enabled pins showing a high level
  logic [15:0] allow2;    // Only line group two may drive
  logic        done_wr;

  assign done_wr = psel & penable & pready & pwrite & ~pslverr;

  // Copy register writes at the edge that completes them
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg <= '{default: 8'h01};
      ring <= 1'b0;
      map2 <= 8'h00;
    end else if (done_wr) begin
      if (paddr[9:4] == 6'h35) cfg[paddr[3:2]] <= pwdata[7:0];
      if (paddr[9:2] == 8'hef) map2 <= pwdata[7:0];
      if (paddr[9:2] == 8'hf5) ring <= pwdata[7];
    end
  end

  // Checks wait until settings have had time to reach the pins
  always_ff @(posedge clk) begin
    if (reset || done_wr) settle <= 5'h00;
    else if (settle != 5'h1f) settle <= settle + 5'h01;
  end

  // Field decode
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      in_dir[i] = cfg[i][0];
      inv[i] = cfg[i][1];
      od[i] = cfg[i][7];
      grp[i] = cfg[i][5];
      fpar[i] = cfg[i][4:3] == 2'h0;
      firq[i] = cfg[i][4:3] == 2'h1;
    end
    act = (pin_in ^ inv) & grp;
    allow2 = (map2[7:4] == 4'h0 || map2[7:4] == 4'h2) ? 16'h0000 : 16'h0001 << map2[7:4];
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  dir_input_a:
    assert property (settle > 5'h3 |-> (in_dir & ~pin_oe_n) == 4'h0) else $error("input driven");
  push_pull_a:
    assert property (settle > 5'h3 |-> (~in_dir & ~od & pin_oe_n) == 4'h0)
      else $error("output not driven");
  open_drain_a:
    assert property (settle > 5'h3 |-> (~in_dir & od & ~pin_oe_n & pin_out) == 4'h0)
      else $error("open drain drives high");
  gpio_level_a:
    assert property (settle > 5'h3 |-> gpio_in_level == ($past(pin_in, 2) ^ inv))
      else $error("level wrong");
  func_off_a:
    assert property (settle > 5'h3 |-> (parallel_data_in & ~fpar) == 4'h0 &&
      (irq_pin_in & ~firq) == 4'h0)
      else $error("unselected function shows data");
  kbc_choice_a:
    assert property (settle > 5'h3 |-> kbc_port_pin_choice == ring) else $error("kbc choice");
  map_decode_a:
    assert property (settle > 5'h3 |-> (isa_irq_two & ~allow2) == 16'h0) else $error("wrong line");
  bypass_irq_a:
    assert property (settle > 5'd3 && !map2[3] && allow2 != 16'h0000 && act != 4'h0
      |-> ##2 (settle < 5'd4 || isa_irq_two == allow2)) else $error("combined line missing");
  debounce_a:
    assert property (settle > 5'h1 && map2[3] && $rose(isa_irq_two != 16'h0000)
      |-> $past(act, 10) != 4'h0) else $error("short event passed filter");
  map_reserved_a:
    assert property (psel && penable && pready && !pwrite && (paddr == 12'h3bc || paddr == 12'h3c0)
      |-> prdata[2:0] == 3'h0) else $error("reserved map bits set");
endmodule

bind gpio_group6_pin_config gpio_cfg_monitor #(.NPIN(NPIN)) mon (.clk(clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n), .parallel_data_in(parallel_data_in), .irq_pin_in(irq_pin_in),
  .kbc_port_pin_choice(kbc_port_pin_choice), .gpio_in_level(gpio_in_level),
  .isa_irq_two(isa_irq_two));

`default_nettype wire

// File: tb/gpio_group6_pin_config_tb.sv
`timescale 1ns/1ps
`default_nettype none

module gpio_group6_pin_config_tb;
  logic        clk, reset, psel, penable, pwrite, pready, pslverr, rerr;
  logic        kbc17, kbc12, kbc_choice, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pin_in, pin_out, pin_oe_n, par_out, par_in, irq_src, irq_in, level;
  logic [3:0]  ext_val, ext_en;
  logic [15:0] isa_one, isa_two, e;
  int          n_mismatch, tests_run, cycles;
  // Output table: config, expected pin_out, expected enable
  logic [7:0]  tcfg [8] = '{8'h10, 8'h12, 8'h90, 8'h92, 8'h00, 8'h02, 8'h08, 8'h18};
  logic [3:0]  tout [8] = '{4'h0, 4'hf, 4'h0, 4'h0, 4'ha, 4'h5, 4'h6, 4'h1};
  logic [3:0]  toen [8] = '{4'h0, 4'h0, 4'h0, 4'hf, 4'h0, 4'h0, 4'h0, 4'h0};
  // Input table: config, parallel, irq and level expected with pins at 9
  logic [7:0]  icfg [3] = '{8'h01, 8'h03, 8'h09};
  logic [3:0]  ipar [3] = '{4'h9, 4'h6, 4'h0};
  logic [3:0]  iirq [3] = '{4'h0, 4'h0, 4'h9};
  logic [3:0]  ilvl [3] = '{4'h9, 4'h6, 4'h9};
  logic [3:0]  codes [6] = '{4'h0, 4'h2, 4'h1, 4'h3, 4'hf, 4'h7};

  gpio_group6_pin_config #(.NPIN(4)) dut (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .parallel_data_out(par_out), .parallel_data_in(par_in),
    .irq_src(irq_src), .irq_pin_in(irq_in), .kbc_port_pin_17(kbc17), .kbc_port_pin_12(kbc12),
    .kbc_port_pin_choice(kbc_choice), .gpio_in_level(level), .isa_irq_one(isa_one),
    .isa_irq_two(isa_two), .irq(irq));
  pin_partner board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val),
    .ext_en(ext_en), .pin_in(pin_in));

  // ----------------------------------------------------------------
  // Clock, hang guard, helpers
  // ----------------------------------------------------------------
  always #2.5 clk = ~clk;

  // A stuck handshake ends the run with a failure
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // One register access: setup, access, hold until ready
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(what, {24'h0, exp}, rdat);
  endtask

  // Raise pin 6.5 for len cycles and collect every line seen then and for 24 cycles after
  task automatic pulse(input string what, input int len, input logic [15:0] exp);
    logic [15:0] seen;
    seen = 16'h0;
    ext_val[1] <= 1'b1;
    repeat (len) begin
      @(posedge clk);
      seen = seen | isa_two;
    end
    ext_val[1] <= 1'b0;
    repeat (24) begin
      @(posedge clk);
      seen = seen | isa_two;
    end
    chk(what, {16'h0, exp}, {16'h0, seen});
  endtask

  task tally_and_finish;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {clk, psel, penable, pwrite, paddr, pwdata} = '0;
    {n_mismatch, tests_run, cycles} = '0;
    reset = 1'b1;
    {par_out, irq_src, kbc17, kbc12, ext_val, ext_en} = {4'ha, 4'h6, 1'b1, 1'b0, 4'h0, 4'h0};
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) rchk("pin cfg reset", 8'hd4 + 8'(i), 8'h01);
    rchk("map two reset", 8'hef, 8'h00);
    rchk("map one reset", 8'hf0, 8'h00);
    chk("oe_n reset", 32'(4'hf), 32'(pin_oe_n));
    apb(1'b1, 8'h00, 8'h55);
    chk("unmapped error", 32'(1'b1), 32'(rerr));
    apb(1'b1, 8'hef, 8'hff);
    rchk("map two mask", 8'hef, 8'hf8);
    apb(1'b1, 8'hf0, 8'h5f);
    rchk("map one mask", 8'hf0, 8'h58);
    apb(1'b1, 8'hd5, 8'hff);
    rchk("pin cfg mask", 8'hd5, 8'hbb);
    // Output drive, polarity and every function code
    for (int k = 0; k < 8; k++) begin
      for (int i = 0; i < 4; i++) apb(1'b1, 8'hd4 + 8'(i), tcfg[k]);
      repeat (2) @(posedge clk);
      chk("pin_oe_n", 32'(toen[k]), 32'(pin_oe_n));
      if (!toen[k]) chk("pin_out", 32'(tout[k]), 32'(pin_out));
    end
    apb(1'b1, 8'hf5, 8'h80);
    repeat (2) @(posedge clk);
    chk("kbc route", 32'(4'h0), 32'(pin_out));
    chk("kbc choice", 32'(1'b1), 32'(kbc_choice));
    // Input direction
    ext_en <= 4'hf;
    ext_val <= 4'h9;
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 4; i++) apb(1'b1, 8'hd4 + 8'(i), icfg[k]);
      repeat (4) @(posedge clk);
      chk("parallel in", 32'(ipar[k]), 32'(par_in));
      chk("irq pin in", 32'(iirq[k]), 32'(irq_in));
      chk("level", 32'(ilvl[k]), 32'(level));
    end
    // Combined interrupt two through pin 6.5
    ext_val <= 4'h0;
    for (int i = 0; i < 4; i++) apb(1'b1, 8'hd4 + 8'(i), (i == 1) ? 8'h31 : 8'h11);
    apb(1'b1, 8'hf9, 8'h02);
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, 8'hef, {codes[k], 4'h0});
      e = (codes[k] == 4'h0 || codes[k] == 4'h2) ? 16'h0 : 16'h1 << codes[k];
      pulse("irq map", 8, e);
    end
    chk("irq sticky", 32'(1'b1), 32'(irq));
    rchk("status", 8'hf8, 8'h02);
    apb(1'b1, 8'hfa, 8'h02);
    rchk("status cleared", 8'hf8, 8'h00);
    chk("irq cleared", 32'(1'b0), 32'(irq));
    apb(1'b1, 8'hf9, 8'h00);
    pulse("masked line", 8, 16'h0080);
    chk("irq masked", 32'(1'b0), 32'(irq));
    apb(1'b1, 8'hf9, 8'h02);
    repeat (2) @(posedge clk);
    chk("irq unmasked", 32'(1'b1), 32'(irq));
    apb(1'b1, 8'hfa, 8'h02);
    apb(1'b1, 8'hd5, 8'h11);
    pulse("not member", 8, 16'h0);
    apb(1'b1, 8'hd5, 8'h31);
    apb(1'b1, 8'hef, 8'h78);
    pulse("short event", 5, 16'h0);
    pulse("long event", 30, 16'h0080);
    apb(1'b1, 8'hf0, 8'h30);
    pulse("group two only", 30, 16'h0080);
    chk("group one idle", 32'(16'h0), 32'(isa_one));
    tally_and_finish();
  end
endmodule

`default_nettype wire
